// ===== buck_pair_phase_config.sv
// pairing scheme selection and channel steering for the buck pair
`include "buck_pair_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module buck_pair_phase_config
    import buck_pair_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] pair_scheme_field_in,
    input wire logic fuse_valid_in,
    input wire logic channel_a_feedback_in,
    input wire logic channel_b_feedback_in,
    input wire channel_ctrl_t channel_a_ctrl_in,
    input wire channel_ctrl_t channel_b_ctrl_in,
    output logic [1:0] pair_scheme_sel_out,
    output logic scheme_locked_out,
    output channel_ctrl_t buck_channel_a_ctrl_out,
    output channel_ctrl_t buck_channel_b_ctrl_out,
    output logic channel_a_feedback_out,
    output logic channel_b_feedback_out,
    output logic channel_a_switch_node_out,
    output logic channel_b_switch_node_out
);
    function automatic pair_scheme_t decode_scheme(input logic [1:0] f);
        pair_scheme_t s;
        s = SCHEME_SINGLE;
        if (f == `SCHEME_DUAL) begin
            s = SCHEME_DUAL;
        end else if (f == `SCHEME_INDEP) begin
            s = SCHEME_INDEP;
        end
        return s;
    endfunction

    // two-flop synchronisers for the pin inputs
    logic fuse_valid_s1_reg;
    logic fuse_valid_s2_reg;
    logic [1:0] field_s1_reg;
    logic [1:0] field_s2_reg;
    logic fb_a_s1_reg;
    logic fb_a_s2_reg;
    logic fb_b_s1_reg;
    logic fb_b_s2_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fuse_valid_s1_reg <= 1'b0;
            fuse_valid_s2_reg <= 1'b0;
            field_s1_reg <= `SCHEME_RESET;
            field_s2_reg <= `SCHEME_RESET;
            fb_a_s1_reg <= 1'b0;
            fb_a_s2_reg <= 1'b0;
            fb_b_s1_reg <= 1'b0;
            fb_b_s2_reg <= 1'b0;
        end else begin
            fuse_valid_s1_reg <= fuse_valid_in;
            fuse_valid_s2_reg <= fuse_valid_s1_reg;
            field_s1_reg <= pair_scheme_field_in;
            field_s2_reg <= field_s1_reg;
            fb_a_s1_reg <= channel_a_feedback_in;
            fb_a_s2_reg <= fb_a_s1_reg;
            fb_b_s1_reg <= channel_b_feedback_in;
            fb_b_s2_reg <= fb_b_s1_reg;
        end
    end


    // scheme capture, once only
    logic locked_reg;
    logic locked_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    pair_scheme_t scheme;

    always_comb begin
        locked_next = locked_reg;
        sel_next = sel_reg;
        if (!locked_reg && fuse_valid_s2_reg) begin // [R6]
            locked_next = 1'b1;
            sel_next = field_s2_reg; // [R1]
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            locked_reg <= 1'b0;
            sel_reg <= `SCHEME_RESET;
        end else begin
            locked_reg <= locked_next;
            sel_reg <= sel_next;
        end
    end
    assign scheme = decode_scheme(sel_reg); // [R1]

    // free-running phase counter
    logic [7:0] phase_reg;
    logic [7:0] phase_next;

    always_comb begin
        phase_next = phase_reg + 8'h01;
        if (phase_reg == `PHASE_PERIOD - 8'h01) begin
            phase_next = `PHASE_RESET;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_reg <= `PHASE_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // switching starts on a period boundary after lock,
    // so the first a pulse is whole; b starts with a, or after it in dual phase
    logic run_reg;
    logic run_next;

    always_comb begin
        run_next = run_reg;
        if (locked_reg && phase_reg == `PHASE_PERIOD - 8'h01) begin
            run_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
        end
    end

    // b runs at a, or half a period behind in dual phase
    logic [7:0] phase_b;
    logic sw_a_next;
    logic sw_b_next;

    always_comb begin
        phase_b = phase_reg;
        if (scheme == SCHEME_DUAL) begin
            if (phase_reg >= `PHASE_HALF) begin // [R3]
                phase_b = phase_reg - `PHASE_HALF;
            end else begin
                phase_b = phase_reg + `PHASE_HALF;
            end
        end
        sw_a_next = run_reg && buck_channel_a_ctrl_out.enable
            && (phase_reg < `PHASE_HALF);
        sw_b_next = run_reg && buck_channel_b_ctrl_out.enable
            && (phase_b < `PHASE_HALF);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            channel_a_switch_node_out <= 1'b0;
            channel_b_switch_node_out <= 1'b0;
        end else begin
            channel_a_switch_node_out <= sw_a_next;
            channel_b_switch_node_out <= sw_b_next;
        end
    end

    // control steering: a governs both unless independent
    channel_ctrl_t ctrl_a_next;
    channel_ctrl_t ctrl_b_next;

    always_comb begin
        ctrl_a_next = channel_a_ctrl_in;
        ctrl_b_next = channel_a_ctrl_in; // [R4]
        if (!locked_reg) begin
            ctrl_a_next = '0;
            ctrl_b_next = '0;
        end else if (scheme == SCHEME_INDEP) begin
            ctrl_b_next = channel_b_ctrl_in; // [R5]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buck_channel_a_ctrl_out <= '0;
            buck_channel_b_ctrl_out <= '0;
        end else begin
            buck_channel_a_ctrl_out <= ctrl_a_next;
            buck_channel_b_ctrl_out <= ctrl_b_next;
        end
    end

    // feedback steering: b pin ignored unless independent
    logic fb_a_next;
    logic fb_b_next;

    always_comb begin
        fb_a_next = fb_a_s2_reg; // [R4]
        fb_b_next = fb_a_s2_reg; // [R4]
        if (!locked_reg) begin
            fb_a_next = 1'b0;
            fb_b_next = 1'b0;
        end else if (scheme == SCHEME_INDEP) begin
            fb_b_next = fb_b_s2_reg; // [R5]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            channel_a_feedback_out <= 1'b0;
            channel_b_feedback_out <= 1'b0;
        end else begin
            channel_a_feedback_out <= fb_a_next;
            channel_b_feedback_out <= fb_b_next;
        end
    end

    // sel and lock flags leave straight from their flops
    assign pair_scheme_sel_out = sel_reg;
    assign scheme_locked_out = locked_reg;
endmodule
`default_nettype wire

// ===== buck_pair_defs.svh
// constants for the buck pair phase configuration block
// Summary of operation
// R1: fuse code picks single, dual or independent
// R2: software writes both channel register sets identically
// R3: dual phase switches channels half period apart
// R4: combined schemes regulate from channel a feedback
// R5: independent scheme uses each channel's own settings
// R6: scheme latched at start-up, never changed after
`ifndef BUCK_PAIR_DEFS_SVH
`define BUCK_PAIR_DEFS_SVH
`define SCHEME_SINGLE_0 2'h0
`define SCHEME_SINGLE_1 2'h1
`define SCHEME_DUAL 2'h2
`define SCHEME_INDEP 2'h3
`define SCHEME_RESET 2'h0
`define PHASE_PERIOD 8'h28
`define PHASE_HALF 8'h14
`define PHASE_RESET 8'h00
`endif

// ===== buck_pair_pkg.sv
// types for the buck pair phase configuration block
package buck_pair_pkg;
    typedef enum logic [1:0] {
        SCHEME_SINGLE = 2'b00,
        SCHEME_DUAL = 2'b01,
        SCHEME_INDEP = 2'b10
    } pair_scheme_t;
    typedef struct packed {
        logic [3:0] channel_switching_mode;
        logic [6:0] voltage_set;
        logic enable;
    } channel_ctrl_t;
endpackage

// ===== buck_pair_phase_config_sva.sv
// assertions for the buck pair phase configuration block
`timescale 1ns/1ps
`default_nettype none
module buck_pair_phase_config_sva
    import buck_pair_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] pair_scheme_sel_out,
    input wire logic scheme_locked_out,
    input wire channel_ctrl_t channel_b_ctrl_in,
    input wire channel_ctrl_t buck_channel_b_ctrl_out,
    input wire logic channel_a_feedback_out,
    input wire logic channel_b_feedback_out,
    input wire logic channel_a_switch_node_out,
    input wire logic channel_b_switch_node_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire lk = scheme_locked_out;
    wire [1:0] s = pair_scheme_sel_out;
    wire asw = channel_a_switch_node_out;
    wire bsw = channel_b_switch_node_out;
    chk_scheme_held: assert property (lk |=> lk && $stable(s))
        else $error("scheme moved after lock");
    chk_indep_own_ctrl: assert property (lk && s == 2'h3 |=>
        buck_channel_b_ctrl_out == $past(channel_b_ctrl_in))
        else $error("channel b not on own control");
    chk_fb_from_a: assert property ((lk && s != 2'h3) [*4] |->
        channel_b_feedback_out == channel_a_feedback_out)
        else $error("channel b loop not on a feedback");
    chk_dual_half_offset: assert property (s == 2'h2 && $rose(asw) |->
        ##20 $rose(bsw)) else $error("dual phase offset wrong");
    chk_single_same: assert property (lk && s < 2'h2 |-> bsw == asw)
        else $error("single phase nodes differ");
    cover property (lk && s == 2'h1);
    cover property (lk && s == 2'h2);
    cover property (lk && s == 2'h3);
endmodule
`default_nettype wire

// ===== testbench.sv
// testbench for the buck pair phase configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import buck_pair_pkg::*;
    logic clk_in = 0, rst_n_in = 0, fv = 0, fa = 0, fb = 0;
    logic [1:0] field = 2'h0, sel;
    logic lk, fao, fbo, asw, bsw;
    channel_ctrl_t ca = '0, cb = '0, ao, bo;
    int err_total = 0, samples_checked = 0, cyc = 0;
    buck_pair_phase_config dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pair_scheme_field_in(field), .fuse_valid_in(fv),
        .channel_a_feedback_in(fa), .channel_b_feedback_in(fb),
        .channel_a_ctrl_in(ca), .channel_b_ctrl_in(cb),
        .pair_scheme_sel_out(sel), .scheme_locked_out(lk),
        .buck_channel_a_ctrl_out(ao), .buck_channel_b_ctrl_out(bo),
        .channel_a_feedback_out(fao), .channel_b_feedback_out(fbo),
        .channel_a_switch_node_out(asw), .channel_b_switch_node_out(bsw));
    initial forever #10 clk_in = ~clk_in;
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_in) if (++cyc > 2000) begin
        err_total++;
        report_and_stop();
    end
    task automatic check(string n, logic [11:0] e, logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic run_scheme(logic [1:0] c);
        int k, n, h;
        @(negedge clk_in) rst_n_in = 0;
        fv = 0;
        field = c;
        repeat (8) @(negedge clk_in);
        rst_n_in = 1;
        check("idle", 12'h0, 12'({sel, lk, asw, bsw}));
        ca = 12'hA5B;
        cb = (c == 2'h3) ? 12'h3C5 : 12'hA5B;
        fa = 1;
        fv = 1;
        for (k = 0; k < 10 && lk !== 1'b1; k++) @(negedge clk_in);
        field = ~c;
        repeat (50) @(negedge clk_in);
        check("sel", 12'(c), 12'(sel));
        check("b_ctrl", (c == 2'h3) ? cb : ca, bo);
        check("b_fb", 12'((c == 2'h3) ? fb : fa), 12'(fbo));
        n = 0;
        h = 0;
        repeat (40) begin
            @(negedge clk_in);
            n += int'(asw === bsw);
            h += int'(asw === 1'b1);
        end
        check("same", (c == 2'h2) ? 12'h0 : 12'h28, 12'(n));
        check("a_high", 12'h14, 12'(h));
    endtask
    initial begin
        for (int i = 0; i < 4; i++) run_scheme(2'(i));
        report_and_stop();
    end
endmodule
bind buck_pair_phase_config buck_pair_phase_config_sva chk (.*);
`default_nettype wire
